// ==== hw/scan_packet_regs.vh ====
`ifndef SCAN_PACKET_REGS_VH
`define SCAN_PACKET_REGS_VH
// Packet byte offsets
`define OFF_DST 8'h00
`define OFF_SRC 8'h06
`define OFF_TYPE_HI 8'h0c
`define OFF_TYPE_LO 8'h0d
`define OFF_SEQ 8'h0e
`define OFF_HDR 8'h0f
`define OFF_VERSION 8'h20
`define OFF_IN_SEL 8'h21
`define OFF_IN_BYTES 8'h22
`define OFF_IN_BITS 8'h23
`define OFF_GO 8'h24
`define OFF_OUT_SEL 8'h28
`define OFF_OUT_BYTES 8'h29
`define OFF_OUT_BITS 8'h2a
`define OFF_FIN_CTRL 8'h2b
`define OFF_FIN_SEL 8'h2c
`define OFF_STATUS 8'h2d
`define OFF_DATA 8'h2e
// Protocol values
`define PKT_TYPE 16'h803a
`define PKT_VERSION 8'h03
`define SEL_SKIP 8'h0f
`define MAX_DATA 11'h050
`define BCAST_BYTE 8'hff
`define GO_BITS 6'h20
// Reset values of the maintenance registers
`define SEL_STOP_RESET 8'hff
`define STOP_N_RESET 4'hf
`define BOOT_CTRL_RESET 8'h00
// APB register byte addresses
`define APB_CTRL 12'h000
`define APB_STATUS 12'h004
`define APB_ACCEPTED 12'h008
`define APB_DROPPED 12'h00c
`define APB_MODES 12'h010
`define CTRL_RESET 1'b1
`endif

// ==== hw/packet_ram.v ====
`timescale 1ns/1ps
`default_nettype none
module packet_ram #(
  parameter AW = 8
) (
  input wire clk_sys_in,
  input wire we_in,
  input wire [AW-1:0] addr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule // packet_ram
`default_nettype wire

// ==== hw/remote_scan_packet_handler.v ====
// What this block does
// - Reply reuses the request layout, fields rewritten
// - Transmit only in answer to requests
// - Execute scans and steps, then one reply
// - Only type 803A packets are accepted
// - Version byte at 0020 reads 3
// - Byte 0021 selects modules during scan-in
// - Scan-in length is bytes then bits
// - Go bits give single-step cycles
// - Scan-out select, bytes, bits at 0028-002A
// - Load control then select registers at end
// - Status byte carries both halt signals
// - Scan data at most 80 bytes
// - Header bytes from 000F left untouched
// - Drop broadcast packets silently
// - Duplicate request resends last reply only
// - Select 0F skips the scan phase
// - Reply swaps source and destination addresses
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scan_packet_regs.vh"
module remote_scan_packet_handler #(
  parameter IDX_W = 7
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire rx_valid_in,
  input wire [7:0] rx_data_in,
  input wire rx_last_in,
  output reg rx_ready_out,
  output reg tx_valid_out,
  output reg [7:0] tx_data_out,
  output reg tx_last_out,
  input wire tx_ready_in,
  output reg scan_mode_out,
  output reg scan_shift_out,
  output reg scan_data_out,
  input wire scan_data_in,
  output reg [7:0] select_stop_out,
  output reg [3:0] stop_n_out,
  output reg [7:0] shift_boot_control_out,
  input wire cpu_halted_n_in,
  input wire mc_halted_in
);
  localparam S_RX = 9'h001, S_CHECK = 9'h002, S_SI_LOAD = 9'h004, S_SI_FETCH = 9'h008, S_SI_SHIFT = 9'h010;
  localparam S_STEP = 9'h020, S_SO_SHIFT = 9'h040, S_FINISH = 9'h080, S_TX = 9'h100;

  function [10:0] bit_total;
    input [7:0] bytes;
    input [7:0] bits;
    begin
      bit_total = {bytes, 3'b000} + {3'b000, bits};
    end
  endfunction
  function [10:0] byte_need;
    input [10:0] total;
    begin
      byte_need = (total + 11'h007) >> 3;
    end
  endfunction

  reg [8:0] state_reg;
  reg enable_reg;
  reg [15:0] accepted_reg, dropped_reg;
  reg rx_bank_reg, reply_bank_reg;
  reg [7:0] rx_len_reg;
  reg bcast_reg;
  reg [47:0] cap_dst_reg, cap_src_reg;
  reg [15:0] cap_type_reg;
  reg [7:0] request_sequence_reg;
  reg [7:0] shift_in_select_value, shift_in_byte_count, shift_in_extra_bits;
  reg [7:0] shift_out_select_value, shift_out_byte_count, shift_out_extra_bits;
  reg [7:0] final_control_value, final_select_value;
  reg [31:0] go_reg;
  reg [5:0] step_cnt_reg;
  reg [10:0] remain_reg;
  reg [2:0] bit_idx_reg;
  reg [6:0] ptr_reg;
  reg [7:0] shreg_reg;
  reg have_last_reg;
  reg [7:0] last_seq_reg;
  reg [47:0] last_src_reg, reply_dst_reg, reply_src_reg;
  reg [7:0] halt_state_byte, reply_len_reg;
  reg [7:0] tx_idx_reg;
  reg [IDX_W-1:0] pend_idx_reg;
  reg pend_reg, pend_last_reg;
  reg [7:0] hold_data_reg;
  reg hold_last_reg, hold_valid_reg;

  wire [10:0] in_total = bit_total(shift_in_byte_count, shift_in_extra_bits);
  wire [10:0] out_total = bit_total(shift_out_byte_count, shift_out_extra_bits);
  wire [10:0] in_need = byte_need(in_total);
  wire [10:0] out_need = byte_need(out_total);
  wire [10:0] out_end = {3'b000, `OFF_DATA} + out_need;
  wire [7:0] rx_next_idx = (rx_len_reg == 8'hff) ? rx_len_reg : rx_len_reg + 8'h01;
  wire [7:0] so_byte = {scan_data_in, shreg_reg[7:1]} >> (3'h7 - bit_idx_reg);
  wire [7:0] data_base = `OFF_DATA;

  // Packet memory port steering
  reg ram_we;
  reg [IDX_W:0] ram_addr;
  reg [7:0] ram_wdata;
  wire [7:0] ram_q;
  always @* begin
    ram_we = 1'b0;
    ram_addr = {rx_bank_reg, rx_len_reg[IDX_W-1:0]};
    ram_wdata = rx_data_in;
    case (state_reg)
      S_RX: ram_we = rx_valid_in & rx_ready_out & ~rx_len_reg[IDX_W];
      S_SI_LOAD: ram_addr = {rx_bank_reg, data_base[IDX_W-1:0] + ptr_reg};
      S_SO_SHIFT: begin
        ram_addr = {rx_bank_reg, data_base[IDX_W-1:0] + ptr_reg};
        ram_wdata = so_byte;
        ram_we = (bit_idx_reg == 3'h7) || (remain_reg == 11'h001);
      end
      S_TX: ram_addr = {reply_bank_reg, tx_idx_reg[IDX_W-1:0]};
      default: ram_we = 1'b0;
    endcase
  end
  packet_ram #(.AW(IDX_W + 1)) u_ram (
    .clk_sys_in(clk_sys_in),
    .we_in(ram_we),
    .addr_in(ram_addr),
    .wdata_in(ram_wdata),
    .rdata_out(ram_q)
  );

  // Reply byte substitution, everything else read from packet memory, where scan-out data has overwritten the received bytes
  reg [7:0] reply_byte;
  always @* begin
    reply_byte = ram_q;
    if (pend_idx_reg < `OFF_SRC) begin
      reply_byte = reply_dst_reg[8*(5-pend_idx_reg) +: 8];
    end else if (pend_idx_reg < `OFF_TYPE_HI) begin
      reply_byte = reply_src_reg[8*(11-pend_idx_reg) +: 8];
    end else if (pend_idx_reg == `OFF_VERSION) begin
      reply_byte = `PKT_VERSION;
    end else if (pend_idx_reg == `OFF_STATUS) begin
      reply_byte = halt_state_byte;
    end
  end

  wire tx_pop = tx_valid_out & tx_ready_in;
  wire tx_space = ({1'b0, tx_valid_out} + {1'b0, hold_valid_reg} + {1'b0, pend_reg}) < 2'h2;
  wire tx_issue = (state_reg == S_TX) && (tx_idx_reg < reply_len_reg) && tx_space;
  wire dup = have_last_reg && (request_sequence_reg == last_seq_reg) && (cap_src_reg == last_src_reg);

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= S_RX;
      rx_ready_out <= 1'b0;
      rx_bank_reg <= 1'b0;
      reply_bank_reg <= 1'b1;
      rx_len_reg <= 8'h00;
      bcast_reg <= 1'b1;
      cap_dst_reg <= 48'h000000000000;
      cap_src_reg <= 48'h000000000000;
      cap_type_reg <= 16'h0000;
      request_sequence_reg <= 8'h00;
      shift_in_select_value <= 8'h00;
      shift_in_byte_count <= 8'h00;
      shift_in_extra_bits <= 8'h00;
      shift_out_select_value <= 8'h00;
      shift_out_byte_count <= 8'h00;
      shift_out_extra_bits <= 8'h00;
      final_control_value <= 8'h00;
      final_select_value <= 8'h00;
      go_reg <= 32'h00000000;
      step_cnt_reg <= 6'h00;
      remain_reg <= 11'h000;
      bit_idx_reg <= 3'h0;
      ptr_reg <= 7'h00;
      shreg_reg <= 8'h00;
      have_last_reg <= 1'b0;
      last_seq_reg <= 8'h00;
      last_src_reg <= 48'h000000000000;
      reply_dst_reg <= 48'h000000000000;
      reply_src_reg <= 48'h000000000000;
      halt_state_byte <= 8'h00;
      reply_len_reg <= 8'h00;
      tx_idx_reg <= 8'h00;
      accepted_reg <= 16'h0000;
      dropped_reg <= 16'h0000;
      scan_mode_out <= 1'b0;
      scan_shift_out <= 1'b0;
      scan_data_out <= 1'b0;
      select_stop_out <= `SEL_STOP_RESET;
      stop_n_out <= `STOP_N_RESET;
      shift_boot_control_out <= `BOOT_CTRL_RESET;
    end else begin
      scan_shift_out <= 1'b0;
      stop_n_out <= ((state_reg == S_STEP) && go_reg[0]) ? `STOP_N_RESET : select_stop_out[3:0];
      rx_ready_out <= (state_reg == S_RX) && !(rx_valid_in && rx_ready_out && rx_last_in);
      case (state_reg)
        S_RX: if (rx_valid_in && rx_ready_out) begin
          rx_len_reg <= rx_next_idx;
          if (rx_len_reg < `OFF_SRC) begin
            cap_dst_reg <= {cap_dst_reg[39:0], rx_data_in};
            bcast_reg <= bcast_reg & (rx_data_in == `BCAST_BYTE);
          end else if (rx_len_reg < `OFF_TYPE_HI) begin
            cap_src_reg <= {cap_src_reg[39:0], rx_data_in};
          end else if (rx_len_reg < `OFF_SEQ) begin
            cap_type_reg <= {cap_type_reg[7:0], rx_data_in};
          end else if (rx_len_reg >= `OFF_GO && rx_len_reg < `OFF_OUT_SEL) begin
            go_reg <= {rx_data_in, go_reg[31:8]};
          end
          case (rx_len_reg)
            `OFF_SEQ: request_sequence_reg <= rx_data_in;
            `OFF_IN_SEL: shift_in_select_value <= rx_data_in;
            `OFF_IN_BYTES: shift_in_byte_count <= rx_data_in;
            `OFF_IN_BITS: shift_in_extra_bits <= rx_data_in;
            `OFF_OUT_SEL: shift_out_select_value <= rx_data_in;
            `OFF_OUT_BYTES: shift_out_byte_count <= rx_data_in;
            `OFF_OUT_BITS: shift_out_extra_bits <= rx_data_in;
            `OFF_FIN_CTRL: final_control_value <= rx_data_in;
            `OFF_FIN_SEL: final_select_value <= rx_data_in;
            default: ;
          endcase
          if (rx_last_in) begin
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          bcast_reg <= 1'b1;
          ptr_reg <= 7'h00;
          bit_idx_reg <= 3'h0;
          remain_reg <= in_total;
          tx_idx_reg <= 8'h00;
          if (!enable_reg || bcast_reg || cap_type_reg != `PKT_TYPE
              || {3'b000, rx_len_reg} < {3'b000, `OFF_DATA} + in_need
              || in_need > `MAX_DATA || out_need > `MAX_DATA) begin
            dropped_reg <= dropped_reg + 16'h0001;
            rx_len_reg <= 8'h00;
            state_reg <= S_RX;
          end else if (dup) begin
            rx_len_reg <= 8'h00;
            state_reg <= S_TX;
          end else begin
            accepted_reg <= accepted_reg + 16'h0001;
            step_cnt_reg <= `GO_BITS;
            if (shift_in_select_value == `SEL_SKIP || in_total == 11'h000) begin
              state_reg <= S_STEP;
            end else begin
              scan_mode_out <= 1'b1;
              select_stop_out <= shift_in_select_value;
              state_reg <= S_SI_LOAD;
            end
          end
        end
        S_SI_LOAD: state_reg <= S_SI_FETCH;
        S_SI_FETCH: begin
          shreg_reg <= ram_q;
          state_reg <= S_SI_SHIFT;
        end
        S_SI_SHIFT: begin
          scan_data_out <= shreg_reg[0];
          scan_shift_out <= 1'b1;
          shreg_reg <= {1'b0, shreg_reg[7:1]};
          remain_reg <= remain_reg - 11'h001;
          bit_idx_reg <= bit_idx_reg + 3'h1;
          if (remain_reg == 11'h001) begin
            state_reg <= S_STEP;
          end else if (bit_idx_reg == 3'h7) begin
            ptr_reg <= ptr_reg + 7'h01;
            state_reg <= S_SI_LOAD;
          end
        end
        S_STEP: begin
          scan_mode_out <= 1'b0;
          go_reg <= {1'b0, go_reg[31:1]};
          step_cnt_reg <= step_cnt_reg - 6'h01;
          if (step_cnt_reg == 6'h01) begin
            ptr_reg <= 7'h00;
            bit_idx_reg <= 3'h0;
            remain_reg <= out_total;
            if (shift_out_select_value == `SEL_SKIP || out_total == 11'h000) begin
              state_reg <= S_FINISH;
            end else begin
              scan_mode_out <= 1'b1;
              select_stop_out <= shift_out_select_value;
              state_reg <= S_SO_SHIFT;
            end
          end
        end
        S_SO_SHIFT: begin
          scan_data_out <= scan_data_in; // Recirculate, scan-out is non-destructive
          scan_shift_out <= 1'b1;
          shreg_reg <= {scan_data_in, shreg_reg[7:1]};
          remain_reg <= remain_reg - 11'h001;
          bit_idx_reg <= bit_idx_reg + 3'h1;
          if (bit_idx_reg == 3'h7) begin
            ptr_reg <= ptr_reg + 7'h01;
          end
          if (remain_reg == 11'h001) begin
            state_reg <= S_FINISH;
          end
        end
        S_FINISH: begin
          scan_mode_out <= 1'b0;
          shift_boot_control_out <= final_control_value;
          select_stop_out <= final_select_value;
          halt_state_byte <= {mc_halted_in, cpu_halted_n_in, 6'h00};
          reply_dst_reg <= cap_src_reg;
          reply_src_reg <= cap_dst_reg;
          reply_len_reg <= (out_end > {3'b000, rx_len_reg}) ? out_end[7:0] : rx_len_reg;
          reply_bank_reg <= rx_bank_reg;
          rx_bank_reg <= ~rx_bank_reg;
          have_last_reg <= 1'b1;
          last_seq_reg <= request_sequence_reg;
          last_src_reg <= cap_src_reg;
          rx_len_reg <= 8'h00;
          state_reg <= S_TX;
        end
        S_TX: begin
          if (tx_issue) begin
            tx_idx_reg <= tx_idx_reg + 8'h01;
          end
          if (tx_idx_reg >= reply_len_reg && !pend_reg && !tx_valid_out && !hold_valid_reg) begin
            state_reg <= S_RX;
          end
        end
        default: state_reg <= S_RX;
      endcase
    end
  end

  // Two-entry transmit buffer, head entry drives the stream outputs
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_reg <= 1'b0;
      pend_last_reg <= 1'b0;
      pend_idx_reg <= {IDX_W{1'b0}};
      tx_valid_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_last_out <= 1'b0;
      hold_valid_reg <= 1'b0;
      hold_data_reg <= 8'h00;
      hold_last_reg <= 1'b0;
    end else begin
      pend_reg <= tx_issue;
      pend_idx_reg <= tx_idx_reg[IDX_W-1:0];
      pend_last_reg <= (tx_idx_reg + 8'h01) == reply_len_reg;
      if (tx_pop && hold_valid_reg) begin
        tx_data_out <= hold_data_reg;
        tx_last_out <= hold_last_reg;
        hold_valid_reg <= pend_reg;
        hold_data_reg <= reply_byte;
        hold_last_reg <= pend_last_reg;
      end else if (tx_pop || !tx_valid_out) begin
        tx_valid_out <= pend_reg;
        tx_data_out <= reply_byte;
        tx_last_out <= pend_last_reg;
      end else if (pend_reg) begin
        hold_valid_reg <= 1'b1;
        hold_data_reg <= reply_byte;
        hold_last_reg <= pend_last_reg;
      end
    end
  end

  // APB slave, one wait state per access
  wire apb_hit = psel_in & penable_in & pready_out;
  wire mapped = (paddr_in == `APB_CTRL) || (paddr_in == `APB_STATUS) || (paddr_in == `APB_ACCEPTED)
                || (paddr_in == `APB_DROPPED) || (paddr_in == `APB_MODES);
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
      enable_reg <= `CTRL_RESET;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
      if (apb_hit && pwrite_in && paddr_in == `APB_CTRL && pstrb_in[0]) begin
        enable_reg <= pwdata_in[0];
      end
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        case (paddr_in)
          `APB_CTRL: prdata_out <= {31'h00000000, enable_reg};
          `APB_STATUS: prdata_out <= {16'h0000, last_seq_reg, 6'h00, have_last_reg, state_reg != S_RX};
          `APB_ACCEPTED: prdata_out <= {16'h0000, accepted_reg};
          `APB_DROPPED: prdata_out <= {16'h0000, dropped_reg};
          `APB_MODES: prdata_out <= {16'h0000, shift_boot_control_out, select_stop_out};
          default: prdata_out <= 32'h00000000;
        endcase
      end else if (apb_hit) begin
        prdata_out <= 32'h00000000;
      end
    end
  end
endmodule // remote_scan_packet_handler
`default_nettype wire

// ==== verification/remote_scan_packet_handler_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scan_packet_regs.vh"
module remote_scan_packet_handler_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  input wire logic rx_ready_out,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_last_out,
  input wire logic tx_ready_in,
  input wire logic scan_mode_out,
  input wire logic scan_shift_out,
  input wire logic [7:0] select_stop_out,
  input wire logic [3:0] stop_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [3:0] sel_low = select_stop_out[3:0];
  a_apb_one_wait:
    assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("apb ready late");
  a_apb_ready_pulse:
    assert property (pready_out |=> !pready_out) else $error("apb ready held");
  a_apb_idle_zero:
    assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out) else $error("apb idle output");
  a_tx_hold_stall:
    assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
    else $error("tx changed in stall");
  a_tx_only_reply:
    assert property (rx_ready_out |-> !tx_valid_out) else $error("tx while receiving");
  a_rx_stop_last:
    assert property (rx_valid_in && rx_ready_out && rx_last_in |=> !rx_ready_out) else $error("rx ready after last");
  a_shift_in_mode:
    assert property (scan_shift_out |-> scan_mode_out && select_stop_out != `SEL_SKIP) else $error("shift outside phase");
  a_stop_follow_sel:
    assert property (stop_n_out != 4'hf |-> stop_n_out == $past(sel_low)) else $error("stop lines wrong");
  c_reply_end: cover property (tx_valid_out && tx_ready_in && tx_last_out);
  c_tx_stall: cover property (tx_valid_out && !tx_ready_in);
  c_shift: cover property (scan_shift_out);
  c_slverr: cover property (pslverr_out);
endmodule // remote_scan_packet_handler_asserts
bind remote_scan_packet_handler remote_scan_packet_handler_asserts u_chk (.*);
`default_nettype wire

// ==== verification/scan_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scan_host_model (
  input wire logic clk_sys_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out,
  input wire logic rx_ready_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out
);
  logic [7:0] pkt [0:159];
  logic [7:0] rep [0:2047];
  int rep_len = 0;
  int stall = 0;
  int cyc = 0;
  int last_at = 0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_last_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // Host starts every exchange
  task automatic send(input int len);
    for (int i = 0; i < len; i++) begin
      rx_valid_out <= 1'b1;
      rx_data_out <= pkt[i];
      rx_last_out <= (i == len - 1);
      @(posedge clk_sys_in iff rx_ready_in);
    end
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_data_out <= ~pkt[len - 1];
  endtask
  // Reply bytes stored in order as received; stalls in bursts
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    tx_ready_out <= (stall == 0) || ((cyc / stall) % 2 == 0);
    if (tx_valid_in && tx_ready_out) begin
      rep[rep_len] <= tx_data_in;
      rep_len <= rep_len + 1;
      if (tx_last_in) last_at <= rep_len + 1;
    end
  end
endmodule // scan_host_model
`default_nettype wire

// ==== verification/remote_scan_packet_handler_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scan_packet_regs.vh"
module remote_scan_packet_handler_tb;
  typedef struct {
    logic [7:0] si, ib, ibt;
    logic [31:0] go;
    logic [7:0] so, ob, obt, fc, fs;
    logic hn, mh, sd;
    int len, st;
  } row_t;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'hf;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, rx_valid_in, rx_last_in, rx_ready_out;
  logic tx_valid_out, tx_last_out, tx_ready_in, scan_mode_out, scan_shift_out, scan_data_out;
  logic [7:0] rx_data_in, tx_data_out, select_stop_out, shift_boot_control_out;
  logic [3:0] stop_n_out;
  logic scan_data_in = 1'b0, cpu_halted_n_in = 1'b1, mc_halted_in = 1'b0;
  int error_cnt = 0, checks_done = 0, shifts = 0, steps = 0;
  int b_rep, nrep, d_shift, d_step;
  logic [3:0] sel_low_reg = 4'hf;
  logic [7:0] want_b [0:159];
  logic [31:0] rd;
  logic err;
  logic [31:0] sig = 32'h0, esig;
  row_t rows [0:3];
  always #12.5 clk_sys_in = ~clk_sys_in;
  // Shift pulses, and forced stop releases while stops asserted
  always @(posedge clk_sys_in) begin
    shifts <= shifts + scan_shift_out;
    steps <= steps + (stop_n_out == 4'hf && sel_low_reg != 4'hf);
    sel_low_reg <= select_stop_out[3:0];
    if (scan_shift_out) sig <= {scan_data_out, sig[31:1]};
  end
  remote_scan_packet_handler dut (.*);
  scan_host_model host (.clk_sys_in(clk_sys_in), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .rx_last_out(rx_last_in), .rx_ready_in(rx_ready_out), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in));
  task automatic report_and_stop;
    $display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input int id);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR %0t item %0d got %h want %h", $time, id, got, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in iff pready_out);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic build(input row_t r, input logic [7:0] seq);
    for (int i = 0; i < 160; i++) host.pkt[i] = 8'(i * 7 + 1);
    for (int i = 0; i < 6; i++) begin
      host.pkt[i] = 8'h20 + i[7:0];
      host.pkt[6 + i] = 8'h50 + i[7:0];
    end
    {host.pkt[12], host.pkt[13], host.pkt[14], host.pkt[32]} = {`PKT_TYPE, seq, 8'h00};
    {host.pkt[33], host.pkt[34], host.pkt[35]} = {r.si, r.ib, r.ibt};
    {host.pkt[39], host.pkt[38], host.pkt[37], host.pkt[36]} = r.go;
    {host.pkt[40], host.pkt[41], host.pkt[42], host.pkt[43], host.pkt[44]} = {r.so, r.ob, r.obt, r.fc, r.fs};
  endtask
  task automatic xfer(input int len);
    int r0, s0, t0;
    r0 = host.rep_len;
    s0 = shifts;
    t0 = steps;
    esig = sig;
    host.send(len);
    @(posedge clk_sys_in iff rx_ready_out);
    repeat (2) @(posedge clk_sys_in);
    b_rep = r0;
    nrep = host.rep_len - r0;
    d_shift = shifts - s0;
    d_step = steps - t0;
  endtask
  task automatic expect_reply(input row_t r);
    int n;
    n = r.ob + ((r.obt != 8'h00) ? 1 : 0);
    for (int i = 0; i < 160; i++) want_b[i] = host.pkt[i];
    for (int i = 0; i < 6; i++) begin
      want_b[i] = host.pkt[6 + i];
      want_b[6 + i] = host.pkt[i];
    end
    want_b[32] = `PKT_VERSION;
    want_b[45] = {r.mh, r.hn, 6'b0};
    for (int i = 0; i < n && r.so != `SEL_SKIP; i++)
      want_b[46 + i] = !r.sd ? 8'h00 : (i < r.ob) ? 8'hff : 8'((1 << r.obt) - 1);
    if (r.si != `SEL_SKIP)
      for (int i = 0; i < 8 * r.ib + r.ibt; i++) esig = {host.pkt[46 + i / 8][i % 8], esig[31:1]};
    if (r.so != `SEL_SKIP)
      for (int i = 0; i < 8 * r.ob + r.obt; i++) esig = {r.sd, esig[31:1]};
  endtask
  initial begin
    rows[0] = '{8'h40, 8'h02, 8'h03, 32'h0000_0001, 8'h0f, 8'h00, 8'h00, 8'h05, 8'hf0, 1'b1, 1'b0, 1'b0, 49, 0};
    rows[1] = '{8'h0f, 8'h03, 8'h00, 32'h8000_000f, 8'h20, 8'h01, 8'h02, 8'h0a, 8'h30, 1'b0, 1'b1, 1'b1, 49, 4};
    rows[2] = '{8'h50, 8'h00, 8'h00, 32'hffff_ffff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0, 46, 2};
    rows[3] = '{8'h60, 8'h50, 8'h00, 32'h0000_0000, 8'h0f, 8'h00, 8'h00, 8'h33, 8'h10, 1'b0, 1'b0, 1'b1, 126, 3};
    repeat (2) @(posedge clk_sys_in);
    chk({select_stop_out, stop_n_out, shift_boot_control_out, tx_valid_out}, {`SEL_STOP_RESET, 4'hf, `BOOT_CTRL_RESET, 1'b0}, 1);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    apb(1'b0, `APB_CTRL, 32'h0);
    chk(rd, {31'h0, `CTRL_RESET}, 2);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd, err}, {32'h0, 1'b1}, 3);
    foreach (rows[k]) begin
      build(rows[k], 8'(k + 1));
      cpu_halted_n_in <= rows[k].hn;
      mc_halted_in <= rows[k].mh;
      scan_data_in <= rows[k].sd;
      host.stall = rows[k].st;
      xfer(rows[k].len);
      expect_reply(rows[k]);
      chk(nrep, rows[k].len, 10);
      for (int i = 0; i < rows[k].len; i++) chk(host.rep[b_rep + i], want_b[i], 100 + i);
      chk(d_shift, (rows[k].si != `SEL_SKIP ? 8 * rows[k].ib + rows[k].ibt : 0)
        + (rows[k].so != `SEL_SKIP ? 8 * rows[k].ob + rows[k].obt : 0), 11);
      chk(d_step, $countones(rows[k].go), 12);
      chk({shift_boot_control_out, select_stop_out}, {rows[k].fc, rows[k].fs}, 13);
      chk(sig, esig, 14);
      chk(host.last_at, host.rep_len, 15);
    end
    // Repeat of the last request with other halt levels
    cpu_halted_n_in <= 1'b1;
    mc_halted_in <= 1'b1;
    xfer(rows[3].len);
    chk(nrep, rows[3].len, 20);
    for (int i = 0; i < rows[3].len; i++) chk(host.rep[b_rep + i], want_b[i], 300 + i);
    chk(d_shift + d_step, 0, 21);
    chk(host.last_at, host.rep_len, 22);
    for (int c = 0; c < 5; c++) begin
      build(rows[0], 8'(20 + c));
      case (c)
        0: for (int i = 0; i < 6; i++) host.pkt[i] = `BCAST_BYTE;
        1: host.pkt[13] = 8'h3b;
        2: host.pkt[34] = 8'h04;
        3: host.pkt[34] = 8'h51;
        default: apb(1'b1, `APB_CTRL, 32'h0);
      endcase
      xfer(c == 3 ? 128 : 49);
      chk(nrep + d_shift + d_step, 0, 30 + c);
    end
    apb(1'b1, `APB_CTRL, 32'h1);
    apb(1'b1, `APB_MODES, 32'hffff_ffff);
    apb(1'b0, `APB_MODES, 32'h0);
    chk(rd[15:0], {rows[3].fc, rows[3].fs}, 40);
    apb(1'b0, `APB_ACCEPTED, 32'h0);
    chk(rd[15:0], 16'h0004, 41);
    apb(1'b0, `APB_DROPPED, 32'h0);
    chk(rd[15:0], 16'h0005, 42);
    apb(1'b0, `APB_STATUS, 32'h0);
    chk(rd[15:8], 8'h04, 43);
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    error_cnt++;
    report_and_stop();
  end
endmodule // remote_scan_packet_handler_tb
`default_nettype wire
